/* File: logic/cfgdec_top.sv */
// Purpose: Holds configuration words 1 to 3 and decodes their fields.
// Assumes: Words come from nonvolatile storage on i_*_word, stable at reset.
// Notes: Decoded settings are captured once, at reset release.
// Behaviour
// - Fail-safe clock monitor runs when word 1 bit 13 is one.
// - Clock switch permit gates software writes to new oscillator/divider fields.
// - External clock or no oscillator: bit 8 zero drives Fosc/4 on pin.
// - Unimplemented configuration bits read as one.
// - Reset oscillator field loads the current oscillator selection at reset.
// - External oscillator mode field selects clock mode and drive power.
// - Debugger enabled when debug bit is zero.
// - Stack overflow/underflow resets device when stack reset bit is one.
// - One-way lock bit allows a single pin map unlock/lock cycle.
// - Zero-cross always on when disable bit zero, else soft enable.
// - Brown-out level bit one selects lower trip level.
// - Brown-out mode: always, run-only, soft-controlled, or disabled.
// - Low-power brown-out enabled when its bit is zero.
// - Power-up timer active when its bit is zero.
// - Without low-voltage programming, master-clear bit picks reset or input.
// - With low-voltage programming, pin is always the master reset.
// - Watchdog clock select: software, low-freq, or medium-freq oscillator.
// - Watchdog window field sets closed/open split and keyed access.
// - Watchdog mode: always, run-only, soft-controlled, or disabled.
// - Decoded settings are valid before the first instruction fetch.
// - Period field in low five bits; 11111 gives software period control.
`timescale 1ns/10ps
`default_nettype none
module cfgdec_top (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [13:0] i_osc_word,
  input wire logic [13:0] i_sup_word,
  input wire logic [13:0] i_wdt_word,
  input wire logic i_low_voltage_prog_enable,
  input wire logic i_sleep,
  input wire logic i_brownout_soft_enable,
  input wire logic i_watchdog_soft_enable,
  input wire logic i_zero_cross_soft_enable,
  input wire logic i_stack_fault,
  input wire logic i_shared_input_pin,
  input wire logic i_osc_div4,
  input wire logic i_pin_map_unlock_seq,
  input wire logic i_pin_map_lock_wr,
  input wire logic i_pin_map_lock_val,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic o_cfg_valid,
  output logic o_failsafe_monitor_enable,
  output logic [2:0] o_current_oscillator_select,
  output logic [2:0] o_external_oscillator_mode,
  output logic o_clock_output_function,
  output logic o_debugger_enable,
  output logic o_stack_reset,
  output logic o_pin_map_lock,
  output logic o_zero_cross_enable,
  output logic o_brownout_level_low,
  output logic o_brownout_enable,
  output logic o_lowpower_brownout_enable,
  output logic o_powerup_timer_enable,
  output logic o_master_clear_reset,
  output logic o_shared_input_value,
  output logic [2:0] o_watchdog_clock_select,
  output logic [2:0] o_watchdog_window_runtime,
  output logic o_watchdog_window_soft,
  output logic o_watchdog_enable,
  output logic [4:0] o_watchdog_period_config,
  output logic o_watchdog_period_soft,
  output logic [2:0] o_new_oscillator_select,
  output logic [3:0] o_new_divider_select
);
  // ****************************************
  // Capture at reset release
  // ****************************************
  logic [13:0] osc_word;
  logic [13:0] sup_word;
  logic [13:0] wdt_word;
  logic loaded;

  // Words are sampled by a clock edge after release, never by the async reset
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_word <= cfgdec_pkg::WORD_ERASED;
      sup_word <= cfgdec_pkg::WORD_ERASED;
      wdt_word <= cfgdec_pkg::WORD_ERASED;
      loaded <= 1'b0;
    end else if (!loaded) begin
      osc_word <= i_osc_word | ~cfgdec_pkg::OSC_IMPL;
      sup_word <= i_sup_word | ~cfgdec_pkg::SUP_IMPL;
      wdt_word <= i_wdt_word | ~cfgdec_pkg::WDT_IMPL;
      loaded <= 1'b1;
    end
  end
  // Core must hold off fetch until this is high
  assign o_cfg_valid = loaded;

  // ****************************************
  // Field decode
  // ****************************************
  logic [2:0] ext_mode;
  logic ec_or_off;
  logic [1:0] bor_mode;
  logic [1:0] wdt_mode;
  logic [2:0] wcws;
  logic low_volt_prog;
  assign ext_mode = osc_word[cfgdec_pkg::B_EXT_MODE +: 3];
  assign ec_or_off = (ext_mode >= cfgdec_pkg::EXT_EC_LO) || (ext_mode == cfgdec_pkg::EXT_OFF);
  assign bor_mode = sup_word[cfgdec_pkg::B_BOR_MODE +: 2];
  assign wdt_mode = wdt_word[cfgdec_pkg::B_WDT_MODE +: 2];
  assign wcws = wdt_word[cfgdec_pkg::B_WCWS +: 3];
  assign low_volt_prog = i_low_voltage_prog_enable;

  assign o_failsafe_monitor_enable = osc_word[cfgdec_pkg::B_FCM];
  assign o_current_oscillator_select = osc_word[cfgdec_pkg::B_RESET_OSC +: 3];
  assign o_external_oscillator_mode = ext_mode;
  // Crystal modes use the pin for the resonator, so the bit is ignored there
  assign o_clock_output_function = ec_or_off && !osc_word[cfgdec_pkg::B_CLKO]
    && i_osc_div4;
  assign o_debugger_enable = !sup_word[cfgdec_pkg::B_DEBUG];
  assign o_stack_reset = sup_word[cfgdec_pkg::B_STACK] && i_stack_fault;
  assign o_zero_cross_enable = !sup_word[cfgdec_pkg::B_ZCD] || i_zero_cross_soft_enable;
  assign o_brownout_level_low = sup_word[cfgdec_pkg::B_BOR_LEVEL];
  always_comb begin
    unique case (bor_mode)
      cfgdec_pkg::MODE_ALWAYS: o_brownout_enable = 1'b1;
      cfgdec_pkg::MODE_RUN: o_brownout_enable = !i_sleep;
      cfgdec_pkg::MODE_SOFT: o_brownout_enable = i_brownout_soft_enable;
      default: o_brownout_enable = 1'b0;
    endcase
  end
  assign o_lowpower_brownout_enable = !sup_word[cfgdec_pkg::B_LPBOR];
  assign o_powerup_timer_enable = !sup_word[cfgdec_pkg::B_POWERUP];
  // Low-voltage programming overrides the enable bit
  assign o_master_clear_reset = (low_volt_prog || sup_word[cfgdec_pkg::B_MASTER_CLEAR])
    && !i_shared_input_pin;
  assign o_shared_input_value = !low_volt_prog && !sup_word[cfgdec_pkg::B_MASTER_CLEAR]
    && i_shared_input_pin;
  assign o_watchdog_clock_select = wdt_word[cfgdec_pkg::B_WCCS +: 3];
  // Both open codes map to the fully open window under software control
  assign o_watchdog_window_soft = (wcws == cfgdec_pkg::WCWS_OPEN)
    || (wcws == cfgdec_pkg::WCWS_OPEN_ALT);
  assign o_watchdog_window_runtime = o_watchdog_window_soft ? cfgdec_pkg::WCWS_OPEN : wcws;
  always_comb begin
    unique case (wdt_mode)
      cfgdec_pkg::MODE_ALWAYS: o_watchdog_enable = 1'b1;
      cfgdec_pkg::MODE_RUN: o_watchdog_enable = !i_sleep;
      cfgdec_pkg::MODE_SOFT: o_watchdog_enable = i_watchdog_soft_enable;
      default: o_watchdog_enable = 1'b0;
    endcase
  end
  assign o_watchdog_period_config = wdt_word[cfgdec_pkg::B_WCPS +: 5];
  assign o_watchdog_period_soft = o_watchdog_period_config == cfgdec_pkg::WCPS_SOFT;

  // ****************************************
  // Pin map lock
  // ****************************************
  logic lock_cycled;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_map_lock <= 1'b0;
      lock_cycled <= 1'b0;
    end else if (loaded && i_pin_map_lock_wr && i_pin_map_unlock_seq) begin
      // One-way mode: once cleared and set again, further writes do nothing
      if (!(sup_word[cfgdec_pkg::B_PPS1] && lock_cycled)) begin
        o_pin_map_lock <= i_pin_map_lock_val;
        if (i_pin_map_lock_val && !o_pin_map_lock) begin
          lock_cycled <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cfgdec_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[3:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == cfgdec_pkg::OFF_CONTROL) ? cfgdec_pkg::RESP_OKAY
          : cfgdec_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Clock switch request; writes dropped when switching is not permitted
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_new_oscillator_select <= 3'h0;
      o_new_divider_select <= 4'h0;
    end else if (!loaded) begin
      // Stored word is not captured yet on this edge, so seed from the input
      o_new_oscillator_select <= i_osc_word[cfgdec_pkg::B_RESET_OSC +: 3];
    end else if (do_write && aw_addr == cfgdec_pkg::OFF_CONTROL && w_strb[0]
      && osc_word[cfgdec_pkg::B_CSW]) begin
      o_new_oscillator_select <= w_data[2:0];
      o_new_divider_select <= w_data[7:4];
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    unique case (s_axi_araddr[3:0])
      cfgdec_pkg::OFF_OSC_WORD: rd_mux = {18'h0, osc_word};
      cfgdec_pkg::OFF_SUP_WORD: rd_mux = {18'h0, sup_word};
      cfgdec_pkg::OFF_WDT_WORD: rd_mux = {18'h0, wdt_word};
      cfgdec_pkg::OFF_CONTROL: rd_mux = {24'h0, o_new_divider_select, 1'b0,
        o_new_oscillator_select};
      default: rd_mux = 32'h0;
    endcase
  end

  // Upper read address bits must be zero, so reads do not alias every 16 bytes
  logic rd_in_map;
  assign rd_in_map = (s_axi_araddr[31:4] == 28'h0);
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= cfgdec_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_in_map ? rd_mux : 32'h0;
      s_axi_rresp <= (!rd_in_map || s_axi_araddr[3:0] > cfgdec_pkg::OFF_CONTROL
        || s_axi_araddr[1:0] != 2'h0) ? cfgdec_pkg::RESP_SLVERR : cfgdec_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_unimpl_ones;
    @(posedge i_mclk) disable iff (!i_reset_n)
      loaded |-> ((osc_word | cfgdec_pkg::OSC_IMPL) == cfgdec_pkg::WORD_ERASED);
  endproperty
  a_unimpl_ones: assert property (p_unimpl_ones) else $error("unimplemented bit low");
  property p_hold;
    @(posedge i_mclk) disable iff (!i_reset_n)
      loaded |=> $stable(osc_word) && $stable(sup_word) && $stable(wdt_word);
  endproperty
  a_hold: assert property (p_hold) else $error("configuration changed after load");
  property p_valid_one;
    @(posedge i_mclk) disable iff (!i_reset_n) !loaded && i_reset_n |=> loaded;
  endproperty
  a_valid_one: assert property (p_valid_one) else $error("load took over one cycle");
  property p_fcm;
    @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(loaded) |-> o_failsafe_monitor_enable == $past(i_osc_word[cfgdec_pkg::B_FCM]);
  endproperty
  a_fcm: assert property (p_fcm) else $error("monitor enable mismatch");
  property p_osc_load;
    @(posedge i_mclk) disable iff (!i_reset_n)
      $rose(loaded) |-> o_new_oscillator_select == o_current_oscillator_select;
  endproperty
  a_osc_load: assert property (p_osc_load) else $error("new select not seeded");
  property p_stack_off;
    @(posedge i_mclk) disable iff (!i_reset_n)
      !sup_word[cfgdec_pkg::B_STACK] |-> !o_stack_reset;
  endproperty
  a_stack_off: assert property (p_stack_off) else $error("stack reset while disabled");
  property p_zcd_forced;
    @(posedge i_mclk) disable iff (!i_reset_n)
      !sup_word[cfgdec_pkg::B_ZCD] |-> o_zero_cross_enable;
  endproperty
  a_zcd_forced: assert property (p_zcd_forced) else $error("zero-cross not forced on");
  property p_csw_block;
    @(posedge i_mclk) disable iff (!i_reset_n)
      loaded && !osc_word[cfgdec_pkg::B_CSW] |=> $stable(o_new_oscillator_select);
  endproperty
  a_csw_block: assert property (p_csw_block) else $error("switch fields changed");
  property p_clock_output_function_xtal;
    @(posedge i_mclk) disable iff (!i_reset_n)
      (ext_mode < cfgdec_pkg::EXT_OFF) |-> !o_clock_output_function;
  endproperty
  a_clock_output_function_xtal: assert property (p_clock_output_function_xtal) else $error("clock out in crystal mode");
  property p_low_volt_reset;
    @(posedge i_mclk) disable iff (!i_reset_n)
      low_volt_prog && !i_shared_input_pin |-> o_master_clear_reset && !o_shared_input_value;
  endproperty
  a_low_volt_reset: assert property (p_low_volt_reset) else $error("pin not a reset");
  property p_wdt_off;
    @(posedge i_mclk) disable iff (!i_reset_n)
      wdt_mode == 2'h0 |-> !o_watchdog_enable;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog on when disabled");
  property p_bor_sleep;
    @(posedge i_mclk) disable iff (!i_reset_n)
      bor_mode == cfgdec_pkg::MODE_RUN && i_sleep |-> !o_brownout_enable;
  endproperty
  a_bor_sleep: assert property (p_bor_sleep) else $error("brown-out on in sleep");
  property p_pps_oneway;
    @(posedge i_mclk) disable iff (!i_reset_n)
      sup_word[cfgdec_pkg::B_PPS1] && lock_cycled && o_pin_map_lock |=> o_pin_map_lock;
  endproperty
  a_pps_oneway: assert property (p_pps_oneway) else $error("one-way lock released");
endmodule
`default_nettype wire

/* File: logic/cfgdec_pkg.sv */
// Purpose: Constants for the configuration word decoder.
// Assumes: 14-bit configuration words, 32-bit AXI4-Lite register bus.
// Notes: Offsets for the three words are local choices.
package cfgdec_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] OFF_OSC_WORD = 4'h0;
  localparam logic [3:0] OFF_SUP_WORD = 4'h4;
  localparam logic [3:0] OFF_WDT_WORD = 4'h8;
  localparam logic [3:0] OFF_CONTROL = 4'hc;
  localparam int WORD_W = 14;
  // Erased state: every bit one
  localparam logic [13:0] WORD_ERASED = 14'h3fff;
  // Implemented bit masks; all other positions read as one
  localparam logic [13:0] OSC_IMPL = 14'h2977;
  localparam logic [13:0] SUP_IMPL = 14'h3ee3;
  localparam logic [13:0] WDT_IMPL = 14'h3f7f;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_FCM = 13;
  localparam int B_CSW = 11;
  localparam int B_CLKO = 8;
  localparam int B_RESET_OSC = 4;
  localparam int B_EXT_MODE = 0;
  localparam int B_DEBUG = 13;
  localparam int B_STACK = 12;
  localparam int B_PPS1 = 11;
  localparam int B_ZCD = 10;
  localparam int B_BOR_LEVEL = 9;
  localparam int B_BOR_MODE = 6;
  localparam int B_LPBOR = 5;
  localparam int B_POWERUP = 1;
  localparam int B_MASTER_CLEAR = 0;
  localparam int B_WCCS = 11;
  localparam int B_WCWS = 8;
  localparam int B_WDT_MODE = 5;
  localparam int B_WCPS = 0;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [2:0] EXT_EC_HI = 3'h7;
  localparam logic [2:0] EXT_EC_LO = 3'h5;
  localparam logic [2:0] EXT_OFF = 3'h4;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_RUN = 2'h2;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [2:0] WCCS_SOFT = 3'h7;
  localparam logic [2:0] WCWS_OPEN = 3'h7;
  localparam logic [2:0] WCWS_OPEN_ALT = 3'h6;
  localparam logic [4:0] WCPS_SOFT = 5'h1f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: bench/test_config_word_decoder.sv */
// Purpose: Self-checking bench for the configuration word decoder.
// Assumes: Words are sampled at reset release; bus requests wait two edges after release.
// Notes: Each word set needs its own reset, since decodes are frozen until the next one.
`timescale 1ns/10ps
`default_nettype none
module test_config_word_decoder;
  logic i_mclk, i_reset_n, i_low_voltage_prog_enable, i_sleep, i_brownout_soft_enable;
  logic i_watchdog_soft_enable, i_zero_cross_soft_enable, i_stack_fault, i_shared_input_pin;
  logic i_osc_div4, i_pin_map_unlock_seq, i_pin_map_lock_wr, i_pin_map_lock_val;
  logic [13:0] i_osc_word, i_sup_word, i_wdt_word;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb, o_new_divider_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic o_cfg_valid, o_failsafe_monitor_enable, o_clock_output_function, o_debugger_enable;
  logic o_stack_reset, o_pin_map_lock, o_zero_cross_enable, o_brownout_level_low;
  logic o_brownout_enable, o_lowpower_brownout_enable, o_powerup_timer_enable;
  logic o_master_clear_reset, o_shared_input_value, o_watchdog_window_soft, o_watchdog_enable;
  logic o_watchdog_period_soft;
  logic [2:0] o_current_oscillator_select, o_external_oscillator_mode, o_watchdog_clock_select;
  logic [2:0] o_watchdog_window_runtime, o_new_oscillator_select;
  logic [4:0] o_watchdog_period_config;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  cfgdec_top DUT (.i_mclk, .i_reset_n, .i_osc_word, .i_sup_word, .i_wdt_word,
    .i_low_voltage_prog_enable, .i_sleep, .i_brownout_soft_enable, .i_watchdog_soft_enable,
    .i_zero_cross_soft_enable, .i_stack_fault, .i_shared_input_pin, .i_osc_div4,
    .i_pin_map_unlock_seq, .i_pin_map_lock_wr, .i_pin_map_lock_val, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .o_cfg_valid,
    .o_failsafe_monitor_enable, .o_current_oscillator_select, .o_external_oscillator_mode,
    .o_clock_output_function, .o_debugger_enable, .o_stack_reset, .o_pin_map_lock,
    .o_zero_cross_enable, .o_brownout_level_low, .o_brownout_enable,
    .o_lowpower_brownout_enable, .o_powerup_timer_enable, .o_master_clear_reset,
    .o_shared_input_value, .o_watchdog_clock_select, .o_watchdog_window_runtime,
    .o_watchdog_window_soft, .o_watchdog_enable, .o_watchdog_period_config,
    .o_watchdog_period_soft, .o_new_oscillator_select, .o_new_divider_select);
  // ****************************************
  // Clock, timeout, checking
  // ****************************************
  initial i_mclk = 1'b0;
  always #20 i_mclk = ~i_mclk;
  // About 260 cycles are needed; the ceiling leaves ample slack
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ****************************************
  // Drivers
  // ****************************************
  task automatic do_reset(input logic [13:0] osc, sup, wdt);
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    i_osc_word <= osc;
    i_sup_word <= sup;
    i_wdt_word <= wdt;
    repeat (5) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  // Handshakes are judged at the falling edge, then acted on at the rising edge
  task automatic axi_write(input logic [31:0] a, d, output logic [1:0] r);
    logic ta, tw, tb, done;
    done = 1'b0;
    @(posedge i_mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge i_mclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge i_mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      done = tb;
    end
    #1;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, done;
    done = 1'b0;
    @(posedge i_mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge i_mclk);
      ta = s_axi_arvalid & s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge i_mclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    #1;
  endtask
  task automatic read_expect(input logic [31:0] a, exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check("read data", d, exp);
    check("read resp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic pin_lock(input logic v, input logic exp);
    @(posedge i_mclk);
    i_pin_map_lock_wr <= 1'b1;
    i_pin_map_lock_val <= v;
    @(posedge i_mclk);
    i_pin_map_lock_wr <= 1'b0;
    #1;
    check("pin map lock", o_pin_map_lock, exp);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_erased();
    logic [1:0] r;
    do_reset(14'h3fff, 14'h3fff, 14'h3fff);
    i_shared_input_pin <= 1'b0;
    i_stack_fault <= 1'b1;
    i_osc_word <= 14'h0000;
    #40;
    check("valid", o_cfg_valid, 1);
    check("failsafe", o_failsafe_monitor_enable, 1);
    check("debugger", o_debugger_enable, 0);
    check("stack reset", o_stack_reset, 1);
    check("zcd soft", o_zero_cross_enable, 0);
    check("bor level", o_brownout_level_low, 1);
    check("lpbor", o_lowpower_brownout_enable, 0);
    check("powerup timer", o_powerup_timer_enable, 0);
    check("master clear", o_master_clear_reset, 1);
    check("clock_output_function off", o_clock_output_function, 0);
    check("new osc", o_new_oscillator_select, 3'h7);
    read_expect(32'h0, 32'h3fff, cfgdec_pkg::RESP_OKAY);
    read_expect(32'h8, 32'h3fff, cfgdec_pkg::RESP_OKAY);
    read_expect(32'h10, 32'h0, cfgdec_pkg::RESP_SLVERR);
    axi_write(32'h0, 32'h0, r);
    check("word write resp", {30'h0, r}, {30'h0, cfgdec_pkg::RESP_SLVERR});
    axi_write(32'hc, 32'h53, r);
    check("select resp", {30'h0, r}, {30'h0, cfgdec_pkg::RESP_OKAY});
    check("new osc", o_new_oscillator_select, 3'h3);
    check("new div", o_new_divider_select, 4'h5);
    $display("test erased done");
  endtask
  task automatic test_zeros();
    logic [1:0] r;
    i_zero_cross_soft_enable <= 1'b0;
    do_reset(14'h0000, 14'h0000, 14'h0000);
    // Unimplemented positions must come back set
    read_expect(32'h0, 32'h1688, cfgdec_pkg::RESP_OKAY);
    read_expect(32'h4, 32'h011c, cfgdec_pkg::RESP_OKAY);
    read_expect(32'h8, 32'h0080, cfgdec_pkg::RESP_OKAY);
    check("failsafe", o_failsafe_monitor_enable, 0);
    check("debugger", o_debugger_enable, 1);
    check("stack reset", o_stack_reset, 0);
    check("zcd forced", o_zero_cross_enable, 1);
    check("bor level", o_brownout_level_low, 0);
    check("lpbor", o_lowpower_brownout_enable, 1);
    check("powerup timer", o_powerup_timer_enable, 1);
    check("clear as input", o_master_clear_reset, 0);
    check("input value", o_shared_input_value, 0);
    i_shared_input_pin <= 1'b1;
    #40;
    check("input value high", o_shared_input_value, 1);
    i_shared_input_pin <= 1'b0;
    i_low_voltage_prog_enable <= 1'b1;
    #40;
    check("clear forced", o_master_clear_reset, 1);
    i_low_voltage_prog_enable <= 1'b0;
    axi_write(32'hc, 32'h53, r);
    check("new osc locked", o_new_oscillator_select, 3'h0);
    check("new div locked", o_new_divider_select, 4'h0);
    $display("test zeros done");
  endtask
  task automatic test_modes();
    logic [13:0] sup, wdt;
    logic e;
    for (int k = 0; k < 4; k++) begin
      sup = 14'h3f3f | 14'(k << 6);
      wdt = 14'h3f9f | 14'(k << 5);
      do_reset(14'h3fff, sup, wdt);
      for (int s = 0; s < 4; s++) begin
        i_sleep <= s[0];
        i_brownout_soft_enable <= s[1];
        i_watchdog_soft_enable <= s[1];
        #40;
        e = (k == 3) ? 1'b1 : (k == 2) ? !s[0] : (k == 1) ? s[1] : 1'b0;
        check("bor enable", o_brownout_enable, e);
        check("wdt enable", o_watchdog_enable, e);
      end
    end
    i_sleep <= 1'b0;
    $display("test modes done");
  endtask
  task automatic test_window();
    logic [4:0] p;
    for (int k = 0; k < 8; k++) begin
      p = (k == 7) ? 5'h1f : 5'(k);
      do_reset(14'h3fff, 14'h3fff, {k[2:0], k[2:0], 3'h7, p});
      check("wdt clock", o_watchdog_clock_select, k[2:0]);
      check("window", o_watchdog_window_runtime, (k == 6) ? 3'h7 : k[2:0]);
      check("window soft", o_watchdog_window_soft, k >= 6);
      check("period", o_watchdog_period_config, p);
      check("period soft", o_watchdog_period_soft, k == 7);
    end
    $display("test window done");
  endtask
  task automatic test_clock_out();
    for (int k = 0; k < 8; k++) begin
      if (k == 3) continue;
      do_reset({6'h3e, 1'b1, k[2:0], 1'b1, k[2:0]}, 14'h3fff, 14'h3fff);
      check("cur osc", o_current_oscillator_select, k[2:0]);
      check("ext mode", o_external_oscillator_mode, k[2:0]);
      for (int d = 0; d < 2; d++) begin
        i_osc_div4 <= d[0];
        #40;
        check("clock_output_function", o_clock_output_function, (k >= 4) & d[0]);
      end
    end
    $display("test clock out done");
  endtask
  task automatic test_lock();
    i_pin_map_unlock_seq <= 1'b1;
    do_reset(14'h3fff, 14'h3fff, 14'h3fff);
    pin_lock(0, 0);
    pin_lock(1, 1);
    pin_lock(0, 1);
    do_reset(14'h3fff, 14'h37ff, 14'h3fff);
    pin_lock(1, 1);
    pin_lock(0, 0);
    pin_lock(1, 1);
    pin_lock(0, 0);
    $display("test lock done");
  endtask
  initial begin
    {i_reset_n, i_low_voltage_prog_enable, i_sleep, i_brownout_soft_enable} = 4'h0;
    {i_watchdog_soft_enable, i_zero_cross_soft_enable, i_stack_fault} = 3'h0;
    {i_shared_input_pin, i_osc_div4, i_pin_map_unlock_seq} = 3'h7;
    {i_pin_map_lock_wr, i_pin_map_lock_val} = 2'h0;
    {i_osc_word, i_sup_word, i_wdt_word} = {3{14'h3fff}};
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {3{32'h0}};
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    test_erased();
    test_zeros();
    test_modes();
    test_window();
    test_clock_out();
    test_lock();
    report_and_stop();
  end
endmodule
`default_nettype wire
